// file: design/irxc_pkg.sv
// Types for the infrared transceiver configuration block
package irxc_pkg;
  typedef enum logic [2:0] {
    IRXC_UART, IRXC_SHARP, IRXC_SIR, IRXC_MIR, IRXC_FIR, IRXC_CEIR
  } irxc_mode_type;
  typedef struct packed {
    logic [2:0] oe;
    logic [2:0] out;
  } irxc_pins_type;
endpackage

// file: design/irxc_regs.svh
// Register offsets, field positions, reset values and timing for irxc
`ifndef IRXC_REGS_SVH
`define IRXC_REGS_SVH
`define IRXC_OFF_CFG1 12'h000
`define IRXC_OFF_CFG2 12'h004
`define IRXC_OFF_CFG3 12'h008
`define IRXC_OFF_CFG4 12'h00c
`define IRXC_OFF_MODE 12'h010
`define IRXC_CFG1_PULSE 7
`define IRXC_CFG1_ID3 3
`define IRXC_CFG4_AUTO 7
`define IRXC_CFG4_SPLIT 6
`define IRXC_CFG4_SEL0DIR 5
`define IRXC_CFG4_INV 4
`define IRXC_CFG4_UPDIR 3
`define IRXC_RST_CFG 8'h00
`define IRXC_CFG4_MASK 8'hf8
`define IRXC_CFG23_MASK 8'h77
`define IRXC_CLK_HZ 25000000
`define IRXC_PULSE_US 64
`define IRXC_PULSE_CYC ((`IRXC_PULSE_US * `IRXC_CLK_HZ) / 1000000)
`endif

// file: design/irxc_top.sv
// Infrared transceiver configuration block with APB register slave
//
// Overview of operation
// (RL1) Upper select pins as inputs: bits read pin levels, writes discarded.
// (RL2) Upper pins output, auto on: bits drive pins only in amplitude-shift mode.
// (RL3) Upper pins output, auto off: bits drive pins in every mode.
// (RL4) Identification bit 3 reads the id input pin; writes ignored.
// (RL5) Auto on, SIR mode: SIR field drives three select pins.
// (RL6) Writing 1 to pulse bit forces transmit high ~64 us, then self-clears.
// (RL7) Each further write of 1 restarts the pulse timer.
// (RL8) Software must not stretch the pulse beyond 64 us; LED damage.
// (RL9) Writing 0 to the pulse bit changes nothing.
// (RL10) Auto on, MIR mode: MIR field drives the select pins.
// (RL11) Auto on, FIR mode: FIR field drives the select pins.
// (RL12) Auto on, remote mode, low band: low-band field drives pins.
// (RL13) Auto on, remote mode, high band: high-band field drives pins.
// (RL14) Mode fields do nothing when auto off or pins are inputs.
// (RL15) Upper direction bit: 0 inputs, 1 outputs.
// (RL16) Receive invert bit inserts inversion in the receive path.
// (RL17) Select0 direction bit: 0 input, 1 output.
// (RL18) Split bit: 0 one common receive input, 1 separate inputs.
// (RL19) Auto bit enables mode-dependent driving of select pins.
// (RL20) Receive input is A, or alternate B/C chosen by aux or speed.
// (RL21) Receive path register resets to all zeros.
// (RL22) After reset select pins are inputs and transmit is low.
// (RL23) Auto on, UART mode: output select pins driven low.
// (RL24) Bit 0 serves select pin 0 like the upper bits.
// (RL25) Subcarrier bit: 0 low band, 1 high band; picks remote field.
// (RL26) Pulse timed by counting clock cycles derived from clock rate.
`timescale 1ns/1ns
`include "irxc_regs.svh"
module irxc_top
  import irxc_pkg::*;
#(
  parameter int PULSE_CYC = `IRXC_PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] xcvr_select_pins_in,
  output logic [2:0] xcvr_select_pins_out,
  output logic [2:0] xcvr_select_pins_oe,
  input wire logic id_input3_pin,
  input wire logic receive_input_a,
  input wire logic receive_input_c,
  output logic ir_transmit_out,
  output logic ir_receive_data
);
  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins
  logic [2:0] sel_s1_r, sel_s2_r;
  logic id3_s1_r, id3_s2_r;
  logic [1:0] rx_s1_r, rx_s2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_s1_r <= 3'h0;
      sel_s2_r <= 3'h0;
      id3_s1_r <= 1'b0;
      id3_s2_r <= 1'b0;
      rx_s1_r <= 2'h0;
      rx_s2_r <= 2'h0;
    end else begin
      sel_s1_r <= xcvr_select_pins_in;
      sel_s2_r <= sel_s1_r;
      id3_s1_r <= id_input3_pin;
      id3_s2_r <= id3_s1_r;
      rx_s1_r <= {receive_input_c, receive_input_a};
      rx_s2_r <= rx_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [2:0] id_ctl_r;
  logic [2:0] low_speed_sir_cfg_r;
  logic [2:0] medium_speed_cfg_r, fast_speed_cfg_r;
  logic [2:0] remote_low_band_cfg_r, remote_high_band_cfg_r;
  logic [7:0] receive_path_config_r;
  logic [2:0] mode_r;
  logic rx_subcarrier_range_r, aux_receive_select_r;
  logic pulse_r;
  logic [31:0] pulse_cnt_r;

  // Writes land only at edges where pready is high; a request held past pready
  // sees it rise again every second cycle, and re-arms the pulse or stores again
  wire logic wr_en = psel & penable & pwrite & pready;
  wire logic rd_en = psel & penable & ~pwrite;
  wire logic hit1 = (paddr == `IRXC_OFF_CFG1);
  wire logic hit2 = (paddr == `IRXC_OFF_CFG2);
  wire logic hit3 = (paddr == `IRXC_OFF_CFG3);
  wire logic hit4 = (paddr == `IRXC_OFF_CFG4);
  wire logic hit5 = (paddr == `IRXC_OFF_MODE);
  wire logic mapped = hit1 | hit2 | hit3 | hit4 | hit5;

  wire logic auto_xcvr_cfg_en = receive_path_config_r[`IRXC_CFG4_AUTO];
  wire logic receive_input_split = receive_path_config_r[`IRXC_CFG4_SPLIT];
  wire logic select0_dir = receive_path_config_r[`IRXC_CFG4_SEL0DIR];
  wire logic receive_invert = receive_path_config_r[`IRXC_CFG4_INV];
  wire logic upper_select_dir = receive_path_config_r[`IRXC_CFG4_UPDIR];
  irxc_mode_type mode_w;
  assign mode_w = irxc_mode_type'(mode_r);
  wire logic high_speed_mode_active =
    (mode_w == IRXC_MIR) | (mode_w == IRXC_FIR);
  wire logic pulse_set = wr_en & hit1 & pwdata[`IRXC_CFG1_PULSE];

  // Pulse timer; a write of 1 reloads, a write of 0 is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_r <= 1'b0; // [RL22]
      pulse_cnt_r <= 32'h0;
    end else if (pulse_set) begin
      pulse_r <= 1'b1; // [RL6] [RL7] [RL9]
      pulse_cnt_r <= 32'(PULSE_CYC - 1); // [RL26]
    end else if (pulse_r) begin
      if (pulse_cnt_r == 32'h0) begin
        pulse_r <= 1'b0; // [RL6]
      end else begin
        pulse_cnt_r <= pulse_cnt_r - 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_ctl_r <= 3'h0;
      low_speed_sir_cfg_r <= 3'h0;
      medium_speed_cfg_r <= 3'h0;
      fast_speed_cfg_r <= 3'h0;
      remote_low_band_cfg_r <= 3'h0;
      remote_high_band_cfg_r <= 3'h0;
      receive_path_config_r <= `IRXC_RST_CFG; // [RL21]
      mode_r <= 3'h0;
      rx_subcarrier_range_r <= 1'b0;
      aux_receive_select_r <= 1'b0;
    end else if (wr_en) begin
      if (hit1) begin
        // Writes land only where the pin is an output [RL1] [RL24]
        if (upper_select_dir) id_ctl_r[2:1] <= pwdata[2:1];
        if (select0_dir) id_ctl_r[0] <= pwdata[0];
        low_speed_sir_cfg_r <= pwdata[6:4];
      end else if (hit2) begin
        medium_speed_cfg_r <= pwdata[2:0];
        fast_speed_cfg_r <= pwdata[6:4];
      end else if (hit3) begin
        remote_low_band_cfg_r <= pwdata[2:0];
        remote_high_band_cfg_r <= pwdata[6:4];
      end else if (hit4) begin
        receive_path_config_r <= pwdata[7:0] & `IRXC_CFG4_MASK;
      end else if (hit5) begin
        mode_r <= pwdata[2:0];
        rx_subcarrier_range_r <= pwdata[4];
        aux_receive_select_r <= pwdata[5];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Select pin drive
  logic [2:0] auto_val;
  logic auto_drive;
  always_comb begin
    auto_drive = 1'b1;
    case (mode_w)
      IRXC_SHARP: auto_val = id_ctl_r; // [RL2] [RL24]
      IRXC_SIR: auto_val = low_speed_sir_cfg_r; // [RL5]
      IRXC_MIR: auto_val = medium_speed_cfg_r; // [RL10]
      IRXC_FIR: auto_val = fast_speed_cfg_r; // [RL11]
      IRXC_CEIR: auto_val = rx_subcarrier_range_r ?
        remote_high_band_cfg_r : remote_low_band_cfg_r; // [RL12] [RL13] [RL25]
      default: auto_val = 3'h0; // [RL23]
    endcase
  end
  // Auto off drives the id bits directly; fields unused then [RL3] [RL14]
  wire logic [2:0] pin_val = auto_xcvr_cfg_en ? auto_val : id_ctl_r; // [RL19]
  wire logic [2:0] pin_oe = {upper_select_dir, upper_select_dir,
    select0_dir}; // [RL15] [RL17]

  // Receive path selection and inversion
  wire logic use_alt = receive_input_split ? high_speed_mode_active
    : aux_receive_select_r; // [RL18] [RL20]
  wire logic alt_in = select0_dir ? rx_s2_r[1] : sel_s2_r[0]; // [RL20]
  wire logic rx_sel = use_alt ? alt_in : rx_s2_r[0];

  logic [7:0] rd_byte;
  always_comb begin
    if (hit1) begin
      rd_byte = {1'b0, low_speed_sir_cfg_r, id3_s2_r, // [RL4]
        upper_select_dir ? id_ctl_r[2:1] : sel_s2_r[2:1],
        select0_dir ? id_ctl_r[0] : sel_s2_r[0]}; // [RL1] [RL24]
    end else if (hit2) begin
      rd_byte = {1'b0, fast_speed_cfg_r, 1'b0, medium_speed_cfg_r};
    end else if (hit3) begin
      rd_byte = {1'b0, remote_high_band_cfg_r, 1'b0, remote_low_band_cfg_r};
    end else if (hit4) begin
      rd_byte = receive_path_config_r;
    end else if (hit5) begin
      rd_byte = {2'h0, aux_receive_select_r, rx_subcarrier_range_r,
        1'b0, mode_r};
    end else begin
      rd_byte = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      xcvr_select_pins_out <= 3'h0;
      xcvr_select_pins_oe <= 3'h0; // [RL22]
      ir_transmit_out <= 1'b0;
      ir_receive_data <= 1'b0;
    end else begin
      // One wait state: pready rises in the second access cycle
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata <= (rd_en & ~pready) ? {24'h0, rd_byte} : 32'h0;
      xcvr_select_pins_out <= pin_val;
      xcvr_select_pins_oe <= pin_oe;
      ir_transmit_out <= pulse_r; // [RL6]
      ir_receive_data <= rx_sel ^ receive_invert; // [RL16]
    end
  end
endmodule // irxc_top

// file: dv/irxc_top_asserts.sv
// Port checker for the infrared transceiver configuration block
`timescale 1ns/1ns
module irxc_top_asserts
  import irxc_pkg::*;
#(
  parameter int PULSE_CYC = 1600
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] xcvr_select_pins_in,
  input wire logic [2:0] xcvr_select_pins_out,
  input wire logic [2:0] xcvr_select_pins_oe,
  input wire logic id_input3_pin,
  input wire logic receive_input_a,
  input wire logic receive_input_c,
  input wire logic ir_transmit_out,
  input wire logic ir_receive_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic arm_w = pready && pwrite && paddr == 12'h000 && pwdata[7];
  wire logic cfg4_wr = pready && pwrite && paddr == 12'h00c;
  // Cycles since the last arming write; saturates so it never wraps
  logic [15:0] tx_cnt_r;
  wire logic [15:0] tx_cnt_nxt = arm_w ? 16'h0 :
    (tx_cnt_r == 16'hffff) ? tx_cnt_r : tx_cnt_r + 16'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_cnt_r <= 16'h0;
    else tx_cnt_r <= tx_cnt_nxt;
  end
  ////////////////////////////////////////////////////////////////////////
  property p_err;
    pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h010);
  endproperty
  a_err: assert property (p_err) else $error("bad error response");
  property p_idle;
    !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_idle: assert property (p_idle) else $error("read bus not idle");
  property p_width;
    pready && !pwrite |-> prdata[31:8] == 24'h0;
  endproperty
  a_width: assert property (p_width) else $error("upper read bits set");
  property p_tx_rise;
    arm_w |-> ##[1:3] ir_transmit_out;
  endproperty
  a_tx_rise: assert property (p_tx_rise) else $error("no pulse");
  property p_tx_len;
    $fell(ir_transmit_out) |-> tx_cnt_r >= PULSE_CYC &&
      tx_cnt_r <= PULSE_CYC + 5;
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("pulse len");
  property p_oe_pair;
    xcvr_select_pins_oe[2] == xcvr_select_pins_oe[1];
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("oe split");
  property p_rst;
    $rose(presetn) |-> xcvr_select_pins_oe == 3'h0 && !ir_transmit_out;
  endproperty
  a_rst: assert property (p_rst) else $error("pins after reset");
  property p_oe_write;
    $changed(xcvr_select_pins_oe) |-> $past(cfg4_wr) || $past(cfg4_wr, 2);
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("oe moved");
  c_pulse: cover property (arm_w);
  c_unmapped: cover property (pready && pslverr);
  c_all_out: cover property (xcvr_select_pins_oe == 3'h7);
endmodule // irxc_top_asserts
bind irxc_top irxc_top_asserts #(.PULSE_CYC(PULSE_CYC)) i_chk (.*);

// file: dv/irxc_top_tb.sv
// Self-checking bench for the infrared transceiver configuration block
`timescale 1ns/1ns
module irxc_top_tb
  import irxc_pkg::*;
;
  localparam int PC = 20; // Short pulse keeps the run brief
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic id3, rx_a, rx_c, tx, rxd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [2:0] pins, p_out, p_oe;
  logic [3:0] id_lvl;
  int n_mismatch, checks_done, n;
  irxc_pins_type drv;
  logic [7:0] md [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h15};
  logic [2:0] ex [7] = '{3'h0, 3'h5, 3'h3, 3'h2, 3'h4, 3'h1, 3'h6};
  logic [7:0] rc4 [7] = '{8'h00, 8'h10, 8'h00, 8'h20, 8'h40, 8'h40, 8'h60};
  logic [7:0] rmd [7] = '{8'h00, 8'h00, 8'h20, 8'h20, 8'h03, 8'h02, 8'h04};
  logic rex [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  assign drv = '{oe: p_oe, out: p_out};
  irxc_top #(.PULSE_CYC(PC)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xcvr_select_pins_in(pins), .xcvr_select_pins_out(p_out),
    .xcvr_select_pins_oe(p_oe), .id_input3_pin(id3),
    .receive_input_a(rx_a), .receive_input_c(rx_c),
    .ir_transmit_out(tx), .ir_receive_data(rxd));
  irxc_xcvr_model i_xcvr (.drv(drv), .id_lvl(id_lvl), .pin_lvl(pins),
    .id3_lvl(id3));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] x, g);
    checks_done++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(input string s, input logic [11:0] a, logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(s, x, rq);
  endtask
  task automatic pulse(input int lo, input int hi);
    n = 0;
    while (tx === 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("pulse length", 32'h1, {31'h0, n >= lo && n <= hi});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {id_lvl, rx_a, rx_c} = 6'b101010;
    n_mismatch = 0;
    checks_done = 0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rc("cfg4 reset", 12'h00c, 32'h0);
    chk("pins reset", 32'h0, {28'h0, p_oe, tx});
    wr(12'h004, 32'hff);
    rc("cfg2", 12'h004, 32'h77);
    wr(12'h008, 32'hff);
    rc("cfg3", 12'h008, 32'h77);
    xfer(1'b0, 12'h014, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, re});
    wr(12'h000, 32'h07);
    rc("cfg1 inputs", 12'h000, 32'h0a);
    wr(12'h00c, 32'h28);
    wr(12'h000, 32'h35);
    repeat (2) @(posedge pclk);
    chk("oe", 32'h7, {29'h0, p_oe});
    chk("out manual", 32'h5, {29'h0, p_out});
    rc("cfg1 outputs", 12'h000, 32'h3d);
    wr(12'h004, 32'h42);
    wr(12'h008, 32'h61);
    wr(12'h00c, 32'ha8);
    foreach (md[i]) begin
      wr(12'h010, {24'h0, md[i]});
      repeat (2) @(posedge pclk);
      chk("auto", {29'h0, ex[i]}, {29'h0, p_out});
    end
    wr(12'h00c, 32'h80);
    repeat (2) @(posedge pclk);
    chk("auto inputs", 32'h0, {29'h0, p_oe});
    foreach (rc4[i]) begin
      wr(12'h00c, {24'h0, rc4[i]});
      wr(12'h010, {24'h0, rmd[i]});
      repeat (4) @(posedge pclk);
      chk("rx", {31'h0, rex[i]}, {31'h0, rxd});
    end
    wr(12'h000, 32'h80);
    wr(12'h000, 32'h00);
    pulse(PC - 5, PC + 1);
    wr(12'h000, 32'h80);
    repeat (10) @(posedge pclk); // One early re-arm only
    wr(12'h000, 32'h80);
    pulse(PC + 2, PC + 6);
    close_out();
  end
  initial begin
    repeat (3000) @(posedge pclk);
    n_mismatch++;
    close_out();
  end
endmodule // irxc_top_tb

// file: dv/irxc_xcvr_model.sv
// Optical transceiver model at the select pins and identity lines
`timescale 1ns/1ns
module irxc_xcvr_model
  import irxc_pkg::*;
(
  input wire irxc_pins_type drv,
  input wire logic [3:0] id_lvl,
  output logic [2:0] pin_lvl,
  output logic id3_lvl
);
  // A pin the block drives shows its level, else the module's id level
  assign pin_lvl = (drv.oe & drv.out) | (~drv.oe & id_lvl[2:0]);
  assign id3_lvl = id_lvl[3];
endmodule // irxc_xcvr_model
